// ### inc/cmp_pkg.sv
// Package with constants, types and the rule overview for the core mode and port register block
// Overview of operation
// - Global disable bit one blocks interrupt service
// - Zero flag set when result is zero
// - Digit carry from bit3; add/sub only
// - Carry: add carry out; subtract not borrow
// - Sleep instruction stops instruction execution
// - Oscillator in sleep follows bit; runs on exit
// - Wake on clear, watchdog, or enabled interrupt
// - Master clear low: reset, halt, pins off
// - Master clear release boots and runs program
// - Shutdown low: lowest power; release does full reset
// - Supply below threshold raises an interrupt
// - Flag latch low nibble is storage, resets ones
// - Flags set by own events, reset zero
// - Mask write-only, resets ones, zero enables
// - Data latch move reads or writes peripheral
// - Address and data latches eight bits, reset ones
// - Peripheral access only while enable bit set
// - Move read pulses read strobe, returns data
package cmp_pkg;
    localparam int          DW            = 8;
    localparam logic [7:0]  FLAG_RST      = 8'h0F;
    localparam logic [7:0]  ONES_RST      = 8'hFF;
    localparam logic [7:0]  STATUS_RST    = 8'h08;
    localparam logic [3:0]  FLAG_HI_MASK  = 4'hF;
    localparam int          ST_C          = 0;
    localparam int          ST_DC         = 1;
    localparam int          ST_Z          = 2;
    localparam int          ST_IOFF       = 3;
    localparam int          OPT_OSC_IN_SLEEP_BIT      = 7;
    localparam int          SETUP_PEN     = 0;
    localparam int          NIB           = 4;
    localparam int          PWR_RST_CYC   = 4;

    // Core operating modes
    typedef enum logic [1:0] {
        CMP_OPERATE,
        CMP_SLEEP,
        CMP_MASTER_CLEAR_N,
        CMP_SHUTDOWN
    } cmp_mode_t;

    // ALU operation classes that touch the status flags
    typedef enum logic [1:0] {
        CMP_ALU_LOGIC,
        CMP_ALU_ADD,
        CMP_ALU_SUB,
        CMP_ALU_NONE
    } cmp_alu_op_t;

    // ALU operation and operands handed in by the datapath
    typedef struct packed {
        logic        valid;
        cmp_alu_op_t op;
        logic [7:0]  a;
        logic [7:0]  b;
    } cmp_alu_req_t;

    // Register write strobes from the core decoder
    typedef struct packed {
        logic       flag_wr;
        logic       mask_wr;
        logic       pdata_wr;
        logic       paddr_wr;
        logic       pdata_mov_rd;
        logic       pdata_mov_wr;
        logic [7:0] wdata;
    } cmp_reg_req_t;

    // Peripheral bus outputs
    typedef struct packed {
        logic       rd_stb;
        logic       wr_stb;
        logic [7:0] addr;
        logic [7:0] data;
    } cmp_pbus_t;
endpackage

// ### core/cmp_sync.sv
// Two-flop synchroniser bank for asynchronous pin inputs
`timescale 1ns/10ps
`default_nettype none
module cmp_sync #(
    parameter int W = 1
) (
    input  wire logic         sys_clk,
    input  wire logic         rst_b,
    input  wire logic         clk_en,
    input  wire logic [W-1:0] async_in,
    input  wire logic [W-1:0] rst_val,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_r;
    logic [W-1:0] meta_nxt;
    logic [W-1:0] sync_nxt;

    // Next values; reset value is a constant supplied by the parent
    always_comb begin
        meta_nxt = meta_r;
        sync_nxt = sync_out;
        if (!rst_b) begin
            meta_nxt = rst_val;
            sync_nxt = rst_val;
        end else if (clk_en) begin
            meta_nxt = async_in;
            sync_nxt = meta_r;
        end
    end

    // First stage is read only by the second
    always_ff @(posedge sys_clk) begin
        meta_r   <= meta_nxt;
        sync_out <= sync_nxt;
    end
endmodule
`default_nettype wire

// ### core/cmp_core_regs.sv
// Core status flags, operating modes and special port registers
`timescale 1ns/10ps
`default_nettype none
module cmp_core_regs
    import cmp_pkg::*;
(
    input  wire logic         sys_clk,
    input  wire logic         rst_b,
    input  wire logic         clk_en,
    input  wire logic         master_clear_n,
    input  wire logic         shutdown_n,
    input  wire logic         analog_supply_good,
    input  wire logic [2:0]   ext_irq,
    input  wire logic         timer_a_ovf,
    input  wire logic         wdt_timeout,
    input  wire logic         sleep_instr,
    input  wire cmp_alu_req_t alu_req,
    input  wire cmp_reg_req_t reg_req,
    input  wire logic         status_wr,
    input  wire logic [7:0]   option_reg,
    input  wire logic [7:0]   setup_reg,
    input  wire logic [7:0]   pbus_rdata,
    output logic [7:0]        status_r,
    output logic [7:0]        flag_rdata_r,
    output logic [7:0]        pdata_rdata_r,
    output logic [7:0]        w_load_data_r,
    output logic              w_load_r,
    output cmp_pbus_t         pbus_r,
    output cmp_mode_t         mode_r,
    output logic              exec_en_r,
    output logic              osc_run_r,
    output logic              irq_service_r,
    output logic              wake_r,
    output logic              gpio_hiz_r,
    output logic              charge_gate_out_r,
    output logic              discharge_gate_out_r,
    output logic              por_req_r
);
    logic [2:0] pin_s;
    logic [2:0] irq_s;
    logic       master_clear_n_s;
    logic       shutdown_n_s;
    logic       sgood_s;
    logic       sgood_d_r;
    logic       sgood_d_nxt;
    logic [2:0] irq_d_r;
    logic [2:0] irq_d_nxt;
    logic [7:0] flag_r;
    logic [7:0] flag_nxt;
    logic [7:0] mask_r;
    logic [7:0] mask_nxt;
    logic [7:0] pdata_r;
    logic [7:0] pdata_nxt;
    logic [7:0] paddr_r;
    logic [7:0] paddr_nxt;
    logic [7:0] status_nxt;
    cmp_pbus_t  pbus_nxt;
    cmp_mode_t  mode_nxt;
    logic [7:0] wl_data_nxt;
    logic       wl_nxt;
    logic       exec_nxt;
    logic       osc_nxt;
    logic       svc_nxt;
    logic       wake_nxt;
    logic       hiz_nxt;
    logic       chg_nxt;
    logic       dis_nxt;
    logic       por_nxt;
    logic [2:0] por_cnt_r;
    logic [2:0] por_cnt_nxt;
    logic       pending;
    logic       pen;
    logic       int_rst;
    logic [8:0] sum9;
    logic [4:0] sum5;

    // Pins come from outside the clock domain
    cmp_sync #(.W(3)) u_pin_sync (
        .sys_clk  (sys_clk),
        .rst_b    (rst_b),
        .clk_en   (clk_en),
        .async_in ({master_clear_n, shutdown_n, analog_supply_good}),
        .rst_val  (3'h7),
        .sync_out (pin_s)
    );
    cmp_sync #(.W(3)) u_irq_sync (
        .sys_clk  (sys_clk),
        .rst_b    (rst_b),
        .clk_en   (clk_en),
        .async_in (ext_irq),
        .rst_val  (3'h0),
        .sync_out (irq_s)
    );
    assign master_clear_n_s  = pin_s[2];
    assign shutdown_n_s  = pin_s[1];
    assign sgood_s = pin_s[0];

    // Add or subtract with carry out; subtract is a + ~b + 1
    function automatic logic [8:0] alu_sum(input logic [7:0] a, input logic [7:0] b,
                                           input logic sub);
        logic [7:0] bb;
        bb = sub ? ~b : b;
        alu_sum = {1'b0, a} + {1'b0, bb} + {8'h00, sub};
    endfunction

    // Low-nibble sum for the digit carry
    function automatic logic [4:0] nib_sum(input logic [3:0] a, input logic [3:0] b,
                                           input logic sub);
        logic [3:0] bb;
        bb = sub ? ~b : b;
        nib_sum = {1'b0, a} + {1'b0, bb} + {4'h0, sub};
    endfunction

    assign int_rst = !master_clear_n_s || !shutdown_n_s;
    assign pen     = setup_reg[SETUP_PEN];
    // Wake uses flag and inverted mask, not the global disable
    assign pending = |(flag_r[7:4] & ~mask_r[7:4]);
    assign sum9    = alu_sum(alu_req.a, alu_req.b, alu_req.op == CMP_ALU_SUB);
    assign sum5    = nib_sum(alu_req.a[3:0], alu_req.b[3:0], alu_req.op == CMP_ALU_SUB);

    // Port latches and status flags
    always_comb begin
        irq_d_nxt   = irq_s;
        sgood_d_nxt = sgood_s;
        flag_nxt    = flag_r;
        mask_nxt    = mask_r;
        pdata_nxt   = pdata_r;
        paddr_nxt   = paddr_r;
        status_nxt  = status_r;
        // Software write first so hardware sets below win
        if (reg_req.flag_wr) begin
            flag_nxt = reg_req.wdata;
        end
        if (reg_req.mask_wr) begin
            mask_nxt = reg_req.wdata;
        end
        if (reg_req.paddr_wr && pen) begin
            paddr_nxt = reg_req.wdata;
        end
        if (reg_req.pdata_wr && !pbus_r.wr_stb) begin
            pdata_nxt = reg_req.wdata;
        end
        if (status_wr) begin
            status_nxt[7:ST_IOFF] = reg_req.wdata[7:ST_IOFF];
        end
        // Rising-edge capture of the external lines and level capture of timer overflow onto sticky flags
        flag_nxt[7:5] = flag_nxt[7:5] | (irq_s & ~irq_d_r);
        if (timer_a_ovf) begin
            flag_nxt[NIB] = 1'b1;
        end
        // Supply drop folded onto the first external flag line
        if (!sgood_s && sgood_d_r) begin
            flag_nxt[5] = 1'b1;
        end
        if (alu_req.valid && alu_req.op != CMP_ALU_NONE) begin
            status_nxt[ST_Z] = (alu_req.op == CMP_ALU_LOGIC) ? (alu_req.a == 8'h00)
                                                             : (sum9[7:0] == 8'h00);
            if (alu_req.op != CMP_ALU_LOGIC) begin
                status_nxt[ST_DC] = sum5[NIB];
                status_nxt[ST_C]  = sum9[DW];
            end
        end
        if (int_rst || !rst_b) begin
            irq_d_nxt   = 3'h0;
            sgood_d_nxt = 1'b1;
            flag_nxt    = FLAG_RST;
            mask_nxt    = ONES_RST;
            pdata_nxt   = ONES_RST;
            paddr_nxt   = ONES_RST;
            status_nxt  = STATUS_RST;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (clk_en) begin
            irq_d_r  <= irq_d_nxt;
            sgood_d_r <= sgood_d_nxt;
            flag_r   <= flag_nxt;
            mask_r   <= mask_nxt;
            pdata_r  <= pdata_nxt;
            paddr_r  <= paddr_nxt;
            status_r <= status_nxt;
        end
    end

    // Mode machine, peripheral strobes and pin controls
    always_comb begin
        mode_nxt    = mode_r;
        pbus_nxt    = pbus_r;
        wl_data_nxt = w_load_data_r;
        wl_nxt      = 1'b0;
        por_cnt_nxt = por_cnt_r;
        por_nxt     = 1'b0;
        wake_nxt    = 1'b0;
        pbus_nxt.rd_stb = 1'b0;
        pbus_nxt.wr_stb = 1'b0;
        // Latches shown on the bus so they stay stable during a strobe
        pbus_nxt.addr = paddr_r;
        pbus_nxt.data = pdata_r;
        case (mode_r)
            CMP_OPERATE: begin
                if (sleep_instr) begin
                    mode_nxt = CMP_SLEEP;
                end else if (pen && reg_req.pdata_mov_rd) begin
                    pbus_nxt.rd_stb = 1'b1;
                    wl_data_nxt     = pbus_rdata;
                    wl_nxt          = 1'b1;
                end else if (pen && reg_req.pdata_mov_wr) begin
                    pbus_nxt.wr_stb = 1'b1;
                end
            end
            CMP_SLEEP: begin
                if (wdt_timeout || pending) begin
                    mode_nxt = CMP_OPERATE;
                    wake_nxt = 1'b1;
                end
            end
            CMP_MASTER_CLEAR_N: begin
                mode_nxt = CMP_OPERATE;
            end
            CMP_SHUTDOWN: begin
                // Full power-on delay before boot
                if (por_cnt_r == 3'(PWR_RST_CYC)) begin
                    mode_nxt = CMP_OPERATE;
                    por_nxt  = 1'b1;
                end else begin
                    por_cnt_nxt = por_cnt_r + 3'h1;
                end
            end
            default: mode_nxt = CMP_OPERATE;
        endcase
        if (!shutdown_n_s) begin
            mode_nxt    = CMP_SHUTDOWN;
            por_cnt_nxt = 3'h0;
        end else if (!master_clear_n_s) begin
            mode_nxt = CMP_MASTER_CLEAR_N;
            wake_nxt = (mode_r == CMP_SLEEP);
        end
        if (int_rst) begin
            pbus_nxt.rd_stb = 1'b0;
            pbus_nxt.wr_stb = 1'b0;
        end
        exec_nxt = (mode_nxt == CMP_OPERATE);
        // Oscillator bit only matters while asleep
        osc_nxt  = (mode_nxt == CMP_OPERATE) || (mode_nxt == CMP_MASTER_CLEAR_N) ||
                   ((mode_nxt == CMP_SLEEP) && option_reg[OPT_OSC_IN_SLEEP_BIT]);
        svc_nxt  = pending && !status_nxt[ST_IOFF] && exec_nxt;
        hiz_nxt  = int_rst;
        chg_nxt  = int_rst;
        dis_nxt  = int_rst;
        if (!rst_b) begin
            mode_nxt    = CMP_MASTER_CLEAR_N;
            pbus_nxt    = '{rd_stb: 1'b0, wr_stb: 1'b0, addr: ONES_RST, data: ONES_RST};
            wl_data_nxt = 8'h00;
            wl_nxt      = 1'b0;
            por_cnt_nxt = 3'h0;
            por_nxt     = 1'b0;
            wake_nxt    = 1'b0;
            exec_nxt    = 1'b0;
            osc_nxt     = 1'b1;
            svc_nxt     = 1'b0;
            hiz_nxt     = 1'b1;
            chg_nxt     = 1'b1;
            dis_nxt     = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (clk_en) begin
            mode_r               <= mode_nxt;
            pbus_r               <= pbus_nxt;
            w_load_data_r        <= wl_data_nxt;
            w_load_r             <= wl_nxt;
            por_cnt_r            <= por_cnt_nxt;
            por_req_r            <= por_nxt;
            wake_r               <= wake_nxt;
            exec_en_r            <= exec_nxt;
            osc_run_r            <= osc_nxt;
            irq_service_r        <= svc_nxt;
            gpio_hiz_r           <= hiz_nxt;
            charge_gate_out_r    <= chg_nxt;
            discharge_gate_out_r <= dis_nxt;
            flag_rdata_r         <= (!rst_b) ? FLAG_RST : flag_nxt;
            pdata_rdata_r        <= (!rst_b) ? ONES_RST : pdata_nxt;
        end
    end
endmodule
`default_nettype wire

// ### sim/cmp_core_regs_monitor.sv
// Concurrent checks on the core mode and port register block
`timescale 1ns/10ps
`default_nettype none
module cmp_core_regs_monitor
    import cmp_pkg::*;
(
    input wire logic         sys_clk,
    input wire logic         rst_b,
    input wire logic         clk_en,
    input wire logic         master_clear_n,
    input wire logic         shutdown_n,
    input wire logic         sleep_instr,
    input wire cmp_alu_req_t alu_req,
    input wire cmp_reg_req_t reg_req,
    input wire logic         status_wr,
    input wire logic [7:0]   setup_reg,
    input wire logic [7:0]   pbus_rdata,
    input wire logic [7:0]   status_r,
    input wire logic [7:0]   w_load_data_r,
    input wire logic         w_load_r,
    input wire cmp_pbus_t    pbus_r,
    input wire cmp_mode_t    mode_r,
    input wire logic         exec_en_r,
    input wire logic         osc_run_r,
    input wire logic         wake_r,
    input wire logic         gpio_hiz_r,
    input wire logic         charge_gate_out_r,
    input wire logic         discharge_gate_out_r,
    input wire logic         por_req_r
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    // Expected add flags, worked out one cycle ahead of the status update
    wire logic [8:0] sum   = {1'b0, alu_req.a} + {1'b0, alu_req.b};
    wire logic [4:0] nib   = {1'b0, alu_req.a[3:0]} + {1'b0, alu_req.b[3:0]};
    wire logic       add_z = (sum[7:0] == 8'h00);
    wire logic [1:0] add_c = {nib[4], sum[8]};
    // Cycles with a status write are skipped too; it writes only bits 7 down to ST_IOFF
    wire logic add_go = alu_req.valid && alu_req.op == CMP_ALU_ADD && clk_en
                        && !status_wr && mode_r == CMP_OPERATE;

    a_add_zero: assert property (add_go |=> status_r[ST_Z] == $past(add_z))
        else $error("zero flag wrong after add");
    a_add_carries: assert property (add_go |=> status_r[1:0] == $past(add_c))
        else $error("carry flags wrong after add");
    a_sleep_entry: assert property (sleep_instr && clk_en && mode_r == CMP_OPERATE
        && master_clear_n && shutdown_n |=> mode_r == CMP_SLEEP)
        else $error("sleep instruction did not enter sleep");
    a_sleep_halts: assert property (mode_r == CMP_SLEEP |-> !exec_en_r)
        else $error("execution running in sleep");
    // A master clear while asleep also wakes, but lands in the clear state first
    a_wake_osc: assert property (wake_r |-> osc_run_r
        && (mode_r == CMP_OPERATE || mode_r == CMP_MASTER_CLEAR_N))
        else $error("oscillator off or not operating at wake");
    a_clear_pins_off: assert property (!master_clear_n [*4] |-> gpio_hiz_r
        && charge_gate_out_r && discharge_gate_out_r && !exec_en_r)
        else $error("pins not off under master clear");
    a_por_pulse: assert property (por_req_r |=> !por_req_r)
        else $error("power-on request longer than one cycle");
    a_mov_enable: assert property (reg_req.pdata_mov_rd && !setup_reg[SETUP_PEN]
        |=> !pbus_r.rd_stb)
        else $error("read strobe while access disabled");
    a_rd_loads_w: assert property (pbus_r.rd_stb |-> w_load_r
        && w_load_data_r == $past(pbus_rdata))
        else $error("read strobe without matching load");
    // Back-to-back moves are legal and give one strobe each, so only a lone move counts
    a_rd_pulse: assert property (pbus_r.rd_stb && clk_en && !reg_req.pdata_mov_rd
        |=> !pbus_r.rd_stb)
        else $error("read strobe longer than one cycle");
    a_wr_pulse: assert property (pbus_r.wr_stb && clk_en && !reg_req.pdata_mov_wr
        && !$past(reg_req.pdata_wr) |=> !pbus_r.wr_stb && $stable(pbus_r.data))
        else $error("write strobe too long or data moved");
endmodule
`default_nettype wire

bind cmp_core_regs cmp_core_regs_monitor u_mon (.sys_clk, .rst_b, .clk_en, .master_clear_n,
    .shutdown_n, .sleep_instr, .alu_req, .reg_req, .status_wr, .setup_reg, .pbus_rdata,
    .status_r, .w_load_data_r, .w_load_r, .pbus_r, .mode_r, .exec_en_r, .osc_run_r, .wake_r,
    .gpio_hiz_r, .charge_gate_out_r, .discharge_gate_out_r, .por_req_r);

// ### sim/cmp_periph_model.sv
// Behavioural peripheral on the internal peripheral bus
`timescale 1ns/10ps
`default_nettype none
module cmp_periph_model
    import cmp_pkg::*;
(
    input  wire logic      sys_clk,
    input  wire cmp_pbus_t pbus_r,
    output logic [7:0]     pbus_rdata,
    output logic [7:0]     last_addr,
    output logic [7:0]     last_data
);
    // Read data follows the address so the bench can predict every read
    assign pbus_rdata = pbus_r.addr ^ 8'hA5;
    // Writes are taken only on the strobe; address and data must be valid then
    always @(posedge sys_clk) begin
        if (pbus_r.wr_stb === 1'b1) begin
            last_addr <= pbus_r.addr;
            last_data <= pbus_r.data;
        end
    end
endmodule
`default_nettype wire

// ### sim/cmp_core_regs_bench.sv
// Self-checking bench for the core mode and port register block
`timescale 1ns/10ps
`default_nettype none
module cmp_core_regs_bench
    import cmp_pkg::*;
;
    logic         sys_clk, rst_b, clk_en, master_clear_n, shutdown_n, analog_supply_good;
    logic         timer_a_ovf, wdt_timeout, sleep_instr, status_wr;
    logic [2:0]   ext_irq;
    logic [7:0]   option_reg, setup_reg, pbus_rdata, status_r, flag_rdata_r, pdata_rdata_r;
    logic [7:0]   w_load_data_r, last_addr, last_data, wd_s;
    logic         w_load_r, exec_en_r, osc_run_r, irq_service_r, wake_r, wl_s;
    logic         gpio_hiz_r, charge_gate_out_r, discharge_gate_out_r, por_req_r;
    cmp_alu_req_t alu_req;
    cmp_reg_req_t reg_req;
    cmp_pbus_t    pbus_r, sb;
    cmp_mode_t    mode_r;
    int           fails, n_tests, cyc;
    // One-hot request codes, in struct field order
    localparam logic [5:0] FLG = 6'h20, MSK = 6'h10, PDW = 6'h08;
    localparam logic [5:0] PAW = 6'h04, MRD = 6'h02, MWR = 6'h01;
    // ALU cases; the logic case follows one with DC set to show it is kept
    cmp_alu_op_t  aop [5] = '{CMP_ALU_ADD, CMP_ALU_SUB, CMP_ALU_ADD, CMP_ALU_LOGIC, CMP_ALU_SUB};
    logic [7:0]   aa [5]  = '{8'h0F, 8'h03, 8'hFF, 8'h01, 8'h05};
    logic [7:0]   ab [5]  = '{8'h01, 8'h05, 8'h01, 8'h00, 8'h05};
    logic [2:0]   az [5]  = '{3'h2, 3'h0, 3'h7, 3'h3, 3'h7};

    cmp_core_regs DUT (.sys_clk, .rst_b, .clk_en, .master_clear_n, .shutdown_n,
        .analog_supply_good, .ext_irq, .timer_a_ovf, .wdt_timeout, .sleep_instr, .alu_req,
        .reg_req, .status_wr, .option_reg, .setup_reg, .pbus_rdata, .status_r, .flag_rdata_r,
        .pdata_rdata_r, .w_load_data_r, .w_load_r, .pbus_r, .mode_r, .exec_en_r, .osc_run_r,
        .irq_service_r, .wake_r, .gpio_hiz_r, .charge_gate_out_r, .discharge_gate_out_r,
        .por_req_r);
    cmp_periph_model u_periph (.sys_clk, .pbus_r, .pbus_rdata, .last_addr, .last_data);

    // 25 MHz clock
    always #20 sys_clk = ~sys_clk;

    // Hang guard: the whole sequence needs about a hundred cycles
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 2000) begin
            fails++;
            results();
        end
    end

    task automatic results();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    // One-cycle register request; the strobes it causes are snapped before release
    task automatic reg_op(input logic [5:0] k, input logic [7:0] d);
        reg_req.wdata = d;
        {reg_req.flag_wr, reg_req.mask_wr, reg_req.pdata_wr, reg_req.paddr_wr,
         reg_req.pdata_mov_rd, reg_req.pdata_mov_wr} = k;
        tick(1);
        sb = pbus_r;
        wl_s = w_load_r;
        wd_s = w_load_data_r;
        reg_req = '0;
        tick(1);
    endtask

    task automatic st_wr(input logic [7:0] d);
        reg_req.wdata = d;
        status_wr = 1'b1;
        tick(1);
        status_wr = 1'b0;
        tick(1);
    endtask

    // Enter sleep and check the halted state and oscillator choice
    task automatic go_sleep(input logic [7:0] o);
        option_reg = o;
        sleep_instr = 1'b1;
        tick(1);
        sleep_instr = 1'b0;
        tick(1);
        chk({6'h00, mode_r}, {6'h00, CMP_SLEEP});
        chk({7'h00, exec_en_r}, 8'h00);
        chk({7'h00, osc_run_r}, {7'h00, o[7]});
    endtask

    // Wake is a one-cycle pulse, so it is looked for at every cycle
    task automatic wait_wake();
        for (int i = 0; i < 12 && wake_r !== 1'b1; i++) tick(1);
        chk({7'h00, wake_r}, 8'h01);
        chk({6'h00, mode_r}, {6'h00, CMP_OPERATE});
        chk({7'h00, osc_run_r}, 8'h01);
    endtask

    initial begin
        {sys_clk, rst_b, timer_a_ovf, wdt_timeout, sleep_instr, status_wr} = '0;
        {clk_en, master_clear_n, shutdown_n, analog_supply_good} = 4'hF;
        {ext_irq, option_reg, setup_reg, alu_req, reg_req} = '0;
        {fails, n_tests, cyc} = '0;
        tick(4);
        rst_b = 1'b1;
        tick(2);
        chk(status_r, 8'h08);
        chk(flag_rdata_r, 8'h0F);
        chk(pdata_rdata_r, 8'hFF);
        chk(pbus_r.addr, 8'hFF);
        $display("reset values done");
        for (int i = 0; i < 5; i++) begin
            alu_req = '{1'b1, aop[i], aa[i], ab[i]};
            tick(1);
            alu_req = '0;
            tick(1);
            chk(status_r, {5'h01, az[i]});
        end
        $display("alu flags done");
        st_wr(8'h00);
        chk(status_r, 8'h07);
        reg_op(MSK, 8'h7F);
        ext_irq = 3'b001;
        tick(5);
        chk(flag_rdata_r, 8'h2F);
        chk({7'h00, irq_service_r}, 8'h00);
        ext_irq = 3'b101;
        tick(5);
        chk(flag_rdata_r, 8'hAF);
        chk({7'h00, irq_service_r}, 8'h01);
        st_wr(8'h08);
        tick(1);
        chk({7'h00, irq_service_r}, 8'h00);
        reg_op(FLG, 8'h05);
        chk(flag_rdata_r, 8'h05);
        // Clock enable low must hold the timer event back until it is raised again
        clk_en = 1'b0;
        timer_a_ovf = 1'b1;
        tick(2);
        chk(flag_rdata_r, 8'h05);
        clk_en = 1'b1;
        tick(1);
        timer_a_ovf = 1'b0;
        tick(1);
        chk(flag_rdata_r, 8'h15);
        ext_irq = 3'b000;
        $display("interrupt flags done");
        go_sleep(8'h00);
        ext_irq = 3'b100;
        wait_wake();
        reg_op(FLG, 8'h0F);
        ext_irq = 3'b000;
        go_sleep(8'h80);
        wdt_timeout = 1'b1;
        tick(1);
        wdt_timeout = 1'b0;
        wait_wake();
        $display("sleep and wake done");
        setup_reg = 8'h01;
        reg_op(PAW, 8'h3C);
        reg_op(MRD, 8'h00);
        chk({6'h00, sb.rd_stb, wl_s}, 8'h03);
        chk(wd_s, 8'h99);
        reg_op(PDW, 8'h96);
        chk(pdata_rdata_r, 8'h96);
        reg_op(MWR, 8'h00);
        chk({7'h00, sb.wr_stb}, 8'h01);
        chk(last_addr, 8'h3C);
        chk(last_data, 8'h96);
        setup_reg = 8'h00;
        reg_op(PAW, 8'h11);
        reg_op(MRD, 8'h00);
        chk({7'h00, sb.rd_stb}, 8'h00);
        chk(sb.addr, 8'h3C);
        $display("peripheral access done");
        analog_supply_good = 1'b0;
        tick(5);
        chk(flag_rdata_r, 8'h2F);
        analog_supply_good = 1'b1;
        master_clear_n = 1'b0;
        tick(5);
        chk({6'h00, mode_r}, {6'h00, CMP_MASTER_CLEAR_N});
        chk({4'h0, gpio_hiz_r, charge_gate_out_r, discharge_gate_out_r, exec_en_r}, 8'h0E);
        chk(flag_rdata_r, 8'h0F);
        master_clear_n = 1'b1;
        tick(6);
        chk({6'h00, mode_r, exec_en_r}, {5'h00, CMP_OPERATE, 1'b1});
        reg_op(PDW, 8'h5A);
        shutdown_n = 1'b0;
        tick(5);
        chk({6'h00, mode_r}, {6'h00, CMP_SHUTDOWN});
        shutdown_n = 1'b1;
        for (int i = 0; i < 12 && por_req_r !== 1'b1; i++) tick(1);
        chk({7'h00, por_req_r}, 8'h01);
        tick(10);
        chk({6'h00, mode_r}, {6'h00, CMP_OPERATE});
        chk(pdata_rdata_r, 8'hFF);
        $display("modes done");
        results();
    end
endmodule
`default_nettype wire
